//--- supply_monitor_defs.svh
// Offsets, field positions, reset values and counts of the supply monitor block.
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH
`define ADR_W 12
`define OFS_FLAGS 12'h00c
`define OFS_FLAG_CLR 12'h010
`define OFS_STATUS 12'h014
`define OFS_UNLOCK 12'h018
`define OFS_CORE_BOD 12'h02c
`define OFS_REF_CAL 12'h030
`define OFS_MID_BOD 12'h034
`define OFS_HIGH_BOD 12'h038
`define OFS_REG_CAL 12'h03c
`define OFS_REG_CTRL 12'h040
`define OFS_SYS_RC 12'h044
`define OFS_MF_RC 12'h048
`define OFS_FAST_RC 12'h058
`define FLAG_CORE 6
`define FLAG_MID 7
`define FLAG_HIGH 8
`define FLAG_AE 31
`define STS_CORE 6
`define STS_MID 7
`define STS_HIGH 8
`define STS_SYS_RC 9
`define STS_FAST_RC 10
`define BOD_EN 0
`define BOD_RST 1
`define LVL_LO 8
`define LVL_W 6
`define LVL_RST 6'h00
`define CAL_W 8
`define CAL_RST 8'h00
`define PAD_W 2
`define PAD_OFF 2'h3
`define PAD_RST 2'h0
`define FREQ_BIT 16
`define FAST_EN 0
`define KEY_LO 24
`define KEY_W 8
// Unlock key value is arbitrary.
`define UNLOCK_KEY 8'haa
`define UNLOCK_ADR_W 10
`define SYS_RC_START 2'h3
`define MASK_MAIN 2'h2
`define BOD_N 3
`define BOD_CORE 0
`define BOD_MID 1
`define BOD_HIGH 2
`define GENERIC_CLOCK_N 12
`define GENERIC_CLOCK_USB 0
`define GENERIC_CLOCK_CAN 1
`define GENERIC_CLOCK_AST 2
`define GENERIC_CLOCK_PWM 4
`define GENERIC_CLOCK_QUADRATURE_DECODER_ZERO 5
`define GENERIC_CLOCK_QUADRATURE_DECODER_ONE 6
`define GENERIC_CLOCK_EVT16 7
`define GENERIC_CLOCK_EVT17 8
`define GENERIC_CLOCK_PIN0 9
`define GENERIC_CLOCK_PIN1 10
`define GENERIC_CLOCK_AUDIO 11
`endif

//--- supply_monitor_pkg.sv
// Types shared by the supply monitor block and its detector qualifier.
package supply_monitor_pkg;
	`include "supply_monitor_defs.svh"
	typedef enum logic [1:0] {BOOT_LOAD = 2'h0, BOOT_RUN = 2'h1} boot_t;
	typedef enum logic [1:0] {Q_OFF = 2'h0, Q_WAIT_RC = 2'h1, Q_WAIT_MAIN = 2'h3,
		Q_LIVE = 2'h2} qual_phase_t;
	typedef struct packed {
		logic sync1;
		logic sync2;
		qual_phase_t phase;
		logic [1:0] cnt;
		logic status;
	} qual_state_t;
	typedef struct packed {
		boot_t boot;
		logic ack;
		logic [31:0] rdata;
		logic armed;
		logic [`UNLOCK_ADR_W-1:0] unlock_adr;
		logic flag_ae;
		logic [`BOD_N-1:0] flag_bod;
		logic [`BOD_N-1:0] sts_prev;
		logic fuse_core_en;
		logic fuse_mid_en;
		logic [`BOD_N-1:0] bod_sw_en;
		logic [1:0] bod_reset_sel;
		logic [`LVL_W-1:0] lvl_core;
		logic [`LVL_W-1:0] lvl_mid;
		logic [`LVL_W-1:0] lvl_high;
		logic [`CAL_W-1:0] ref_cal;
		logic [`CAL_W-1:0] reg_cal;
		logic [`CAL_W-1:0] sys_cal;
		logic [`CAL_W-1:0] mf_cal;
		logic [`PAD_W-1:0] pad_ctl;
		logic freq_sel;
		logic fast_en;
		logic rc_prev;
		logic [1:0] rc_cnt;
		logic sys_ready;
		logic [`BOD_N-1:0] bod_en_q;
		logic core_irq;
		logic core_rst;
		logic mid_irq;
		logic mid_rst;
		logic high_irq;
		logic bandgap_on;
		logic sys_rc_en;
		logic fast_rc_run;
		logic pad_on;
		logic [`GENERIC_CLOCK_N-1:0] generic_clock_q;
	} main_state_t;
endpackage : supply_monitor_pkg

//--- brownout_qualifier.sv
// Synchroniser and turn-on mask for one brown-out detector output.
`timescale 1ns/100ps
`include "supply_monitor_defs.svh"
module brownout_qualifier (
	input wire logic clk_sys_in, // Bus clock.
	input wire logic rst_n_in, // Asynchronous reset, active low.
	input wire logic enable_in, // Detector enabled.
	input wire logic raw_in, // Raw analog comparator output.
	input wire logic rc_toggle_in, // System RC level changed this cycle.
	output logic status_out // Qualified detector output.
);
	import supply_monitor_pkg::*;
	qual_state_t s;
	qual_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.sync1 = raw_in; // R22
		next_s.sync2 = s.sync1; // R22
		case (s.phase)
			Q_OFF: begin
				if (enable_in) next_s.phase = Q_WAIT_RC;
			end
			Q_WAIT_RC: begin
				// The first RC clock level change seen here comes at most half its period after entry.
				if (rc_toggle_in) begin
					next_s.phase = Q_WAIT_MAIN; // R7
					next_s.cnt = 2'h0;
				end
			end
			Q_WAIT_MAIN: begin
				next_s.cnt = s.cnt + 2'h1;
				if (s.cnt == `MASK_MAIN - 2'h1) next_s.phase = Q_LIVE; // R7
			end
			Q_LIVE: ;
			default: next_s.phase = Q_OFF;
		endcase
		if (!enable_in) next_s.phase = Q_OFF;
		next_s.status = (s.phase == Q_LIVE) && enable_in && s.sync2; // R7
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign status_out = s.status;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence turn_on;
		$rose(enable_in);
	endsequence
	a_mask_after_enable: assert property (turn_on |-> !status_out [*4]) // R7
		else $error("detector output not masked after enable");
	a_disabled_quiet: assert property (!enable_in |=> !status_out) // R22
		else $error("disabled detector shows output");
endmodule : brownout_qualifier

//--- supply_monitor_and_rc_source_control.sv
// Supply monitors, bandgap, regulators, RC oscillators and generic clock routing.
// Functional notes
// [R1] Software disables a generic clock glitch-free before changing its source or divider.
// [R2] Generic clocks 0-6 and 11 feed USB, CAN, timer, none, PWM, decoders, audio.
// [R3] Generic clocks 7, 8 become events 16, 17; 9, 10 drive output pins.
// [R4] Core detector uses its level; off at reset, enabled by software or fuse.
// [R5] Core detector gives interrupt or reset as selected; status bit mirrors it.
// [R6] Software changes a detector level only while that detector is off.
// [R7] Detector output masked half a system RC period plus two clocks after enable.
// [R8] Debug ports enabled mask core, mid reset and interrupt, and high interrupt.
// [R9] Mid detector: off at reset, software or fuse enable, interrupt or reset, status.
// [R10] High detector: software enable only, interrupt only, own status bit.
// [R11] Writes to protected control registers need a correct preceding unlock.
// [R12] Bandgap on at startup, off in deep stop and static sleep.
// [R13] Reference, core regulator and system RC calibration load from fuses after reset.
// [R14] Both regulators on at startup; writing 11 to pad field turns pad regulator off.
// [R15] System RC usable three RC cycles after start, off only in static sleep.
// [R16] Multi-frequency RC runs at 8 or 1 MHz by its frequency select bit.
// [R17] Multi-frequency calibration loads factory trim after reset; software may rewrite it.
// [R18] Fast RC enable bit reads one only once the oscillator runs.
// [R19] Fast RC stopped automatically in the sleep modes that remove it.
// [R20] Protected write without correct unlock sets the access error flag.
// [R21] Each brown-out flag sets on a rising edge of its status bit.
// [R22] Detector outputs are synchronised into the bus clock before use.
`timescale 1ns/100ps
`include "supply_monitor_defs.svh"
module supply_monitor_and_rc_source_control (
	input wire logic clk_sys_in, // Bus clock, 125 MHz.
	input wire logic rst_n_in, // Power-on reset, asynchronous, active low.
	input wire logic wb_cyc_in, // Wishbone cycle.
	input wire logic wb_stb_in, // Wishbone strobe.
	input wire logic wb_we_in, // Wishbone write enable.
	input wire logic [`ADR_W-1:0] wb_adr_in, // Wishbone byte address.
	input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_in, // Wishbone write data.
	output logic [31:0] wb_dat_out, // Wishbone read data.
	output logic wb_ack_out, // Wishbone acknowledge.
	input wire logic [`BOD_N-1:0] bod_raw_in, // Raw detector outputs, core mid high.
	input wire logic sys_rc_clk_in, // System RC clock level.
	input wire logic jtag_enable_in, // Boundary-scan port enabled.
	input wire logic single_wire_debug_port_in, // Single-wire debug port enabled.
	input wire logic deep_stop_sleep_in, // Deep-stop sleep active.
	input wire logic static_sleep_in, // Static sleep active.
	input wire logic fast_rc_off_sleep_in, // Sleep mode that removes the fast RC.
	input wire logic fast_rc_ready_in, // Fast RC oscillator running.
	input wire logic fuse_core_bod_en_in, // Fuse enables core detector.
	input wire logic fuse_mid_bod_en_in, // Fuse enables mid detector.
	input wire logic [`CAL_W-1:0] fuse_reference_cal_in, // Fuse bandgap trim.
	input wire logic [`CAL_W-1:0] fuse_core_reg_cal_in, // Fuse core regulator trim.
	input wire logic [`CAL_W-1:0] fuse_sys_rc_cal_in, // Fuse system RC trim.
	input wire logic [`CAL_W-1:0] factory_multi_freq_trim_in, // Factory multi-freq trim.
	input wire logic [`GENERIC_CLOCK_N-1:0] generic_clock_in, // Generic clock enables by index.
	output logic [`BOD_N-1:0] bod_enable_out, // Detector enables, core mid high.
	output logic [`LVL_W-1:0] core_bod_level_out, // Core detector threshold.
	output logic [`LVL_W-1:0] mid_bod_level_out, // Mid detector threshold.
	output logic [`LVL_W-1:0] high_bod_level_out, // High detector threshold.
	output logic core_bod_irq_out, // Core detector interrupt request.
	output logic core_bod_reset_out, // Core detector reset request.
	output logic mid_bod_irq_out, // Mid detector interrupt request.
	output logic mid_bod_reset_out, // Mid detector reset request.
	output logic high_bod_irq_out, // High detector interrupt request.
	output logic bandgap_on_out, // Bandgap reference enable.
	output logic [`CAL_W-1:0] reference_calibration_out, // Bandgap trim.
	output logic [`CAL_W-1:0] core_regulator_calibration_out, // Core regulator trim.
	output logic pad_regulator_on_out, // USB pad regulator enable.
	output logic sys_rc_enable_out, // System RC enable.
	output logic sys_rc_ready_out, // System RC usable.
	output logic [`CAL_W-1:0] system_rc_calibration_out, // System RC trim.
	output logic frequency_select_bit_out, // Multi-freq RC, 1 selects 1 MHz.
	output logic [`CAL_W-1:0] multi_freq_calibration_out, // Multi-freq RC trim.
	output logic fast_rc_enable_out, // Fast RC oscillator enable.
	output logic usb_clock_out, // Generic clock for USB, 48 MHz.
	output logic can_interface_clock_out, // Generic clock for CAN.
	output logic asynchronous_timer_clock_out, // Generic clock for timer.
	output logic pwm_clock_out, // Generic clock for PWM.
	output logic quadrature_decoder_zero_clock_out, // Generic clock for decoder 0.
	output logic quadrature_decoder_one_clock_out, // Generic clock for decoder 1.
	output logic generic_clock_event16_out, // Event 16 to the event controller.
	output logic generic_clock_event17_out, // Event 17 to the event controller.
	output logic [1:0] generic_clock_pin_out, // Generic clock output pins.
	output logic audio_serial_controller_clock_out // Generic clock for audio.
);
	import supply_monitor_pkg::*;
	main_state_t s;
	main_state_t next_s;
	logic [`BOD_N-1:0] status;
	logic take;
	logic wr;
	logic [`ADR_W-1:0] adr_w;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic [31:0] wd;
	logic [31:0] clr;
	logic prot;
	logic allowed;
	logic dbg;
	logic [`BOD_N-1:0] rise;

	genvar g;
	generate
		for (g = 0; g < `BOD_N; g++) begin : gen_bod
			brownout_qualifier u_qual (
				.clk_sys_in(clk_sys_in),
				.rst_n_in(rst_n_in),
				.enable_in(s.bod_en_q[g]),
				.raw_in(bod_raw_in[g]),
				.rc_toggle_in(sys_rc_clk_in ^ s.rc_prev),
				.status_out(status[g])
			);
		end
	endgenerate

	function automatic logic [31:0] read_reg(input main_state_t st, input logic [`ADR_W-1:0] a,
		input logic [`BOD_N-1:0] sts, input logic fast_rdy);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`OFS_FLAGS: begin
				r[`FLAG_CORE] = st.flag_bod[`BOD_CORE];
				r[`FLAG_MID] = st.flag_bod[`BOD_MID];
				r[`FLAG_HIGH] = st.flag_bod[`BOD_HIGH];
				r[`FLAG_AE] = st.flag_ae;
			end
			`OFS_STATUS: begin
				r[`STS_CORE] = sts[`BOD_CORE]; // R5
				r[`STS_MID] = sts[`BOD_MID]; // R9
				r[`STS_HIGH] = sts[`BOD_HIGH]; // R10
				r[`STS_SYS_RC] = st.sys_ready;
				r[`STS_FAST_RC] = st.fast_en & fast_rdy;
			end
			`OFS_CORE_BOD: begin
				r[`BOD_EN] = st.bod_sw_en[`BOD_CORE];
				r[`BOD_RST] = st.bod_reset_sel[`BOD_CORE];
				r[`LVL_LO +: `LVL_W] = st.lvl_core;
			end
			`OFS_MID_BOD: begin
				r[`BOD_EN] = st.bod_sw_en[`BOD_MID];
				r[`BOD_RST] = st.bod_reset_sel[`BOD_MID];
				r[`LVL_LO +: `LVL_W] = st.lvl_mid;
			end
			`OFS_HIGH_BOD: begin
				r[`BOD_EN] = st.bod_sw_en[`BOD_HIGH];
				r[`LVL_LO +: `LVL_W] = st.lvl_high;
			end
			`OFS_REF_CAL: r[`CAL_W-1:0] = st.ref_cal;
			`OFS_REG_CAL: r[`CAL_W-1:0] = st.reg_cal;
			`OFS_REG_CTRL: r[`PAD_W-1:0] = st.pad_ctl;
			`OFS_SYS_RC: r[`CAL_W-1:0] = st.sys_cal;
			`OFS_MF_RC: begin
				r[`CAL_W-1:0] = st.mf_cal;
				r[`FREQ_BIT] = st.freq_sel;
			end
			`OFS_FAST_RC: r[`FAST_EN] = st.fast_en & fast_rdy; // R18
			default: r = 32'h0;
		endcase
		return r;
	endfunction : read_reg

	function automatic logic is_protected(input logic [`ADR_W-1:0] a);
		case (a)
			`OFS_CORE_BOD, `OFS_REF_CAL, `OFS_MID_BOD, `OFS_HIGH_BOD: return 1'b1;
			`OFS_REG_CAL, `OFS_REG_CTRL, `OFS_SYS_RC, `OFS_MF_RC: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_protected

	assign take = wb_cyc_in && wb_stb_in && !s.ack && (s.boot == BOOT_RUN);
	assign wr = take && wb_we_in;
	assign adr_w = {wb_adr_in[`ADR_W-1:2], 2'h0};
	assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	assign rd_word = read_reg(s, adr_w, status, fast_rc_ready_in);
	assign wd = (rd_word & ~wmask) | (wb_dat_in & wmask);
	assign clr = (wr && adr_w == `OFS_FLAG_CLR) ? (wb_dat_in & wmask) : 32'h0;
	assign prot = is_protected(adr_w);
	assign allowed = s.armed && (s.unlock_adr == adr_w[`UNLOCK_ADR_W-1:0]); // R11
	assign dbg = jtag_enable_in || single_wire_debug_port_in;
	assign rise = status & ~s.sts_prev; // R21

	always_comb begin
		next_s = s;
		next_s.ack = take;
		next_s.rdata = (take && !wb_we_in) ? rd_word : 32'h0;
		if (s.boot == BOOT_LOAD) begin
			next_s.boot = BOOT_RUN;
			next_s.ref_cal = fuse_reference_cal_in; // R13
			next_s.reg_cal = fuse_core_reg_cal_in; // R13
			next_s.sys_cal = fuse_sys_rc_cal_in; // R13
			next_s.mf_cal = factory_multi_freq_trim_in; // R17
			next_s.fuse_core_en = fuse_core_bod_en_in; // R4
			next_s.fuse_mid_en = fuse_mid_bod_en_in; // R9
		end
		if (wr) begin
			next_s.armed = 1'b0;
			if (adr_w == `OFS_UNLOCK && wd[`KEY_LO +: `KEY_W] == `UNLOCK_KEY) begin
				next_s.armed = 1'b1;
				next_s.unlock_adr = wd[`UNLOCK_ADR_W-1:0];
			end
			if (!prot || allowed) begin // R11
				case (adr_w)
					`OFS_CORE_BOD: begin
						next_s.bod_sw_en[`BOD_CORE] = wd[`BOD_EN]; // R4
						next_s.bod_reset_sel[`BOD_CORE] = wd[`BOD_RST]; // R5
						next_s.lvl_core = wd[`LVL_LO +: `LVL_W];
					end
					`OFS_MID_BOD: begin
						next_s.bod_sw_en[`BOD_MID] = wd[`BOD_EN]; // R9
						next_s.bod_reset_sel[`BOD_MID] = wd[`BOD_RST];
						next_s.lvl_mid = wd[`LVL_LO +: `LVL_W];
					end
					`OFS_HIGH_BOD: begin
						next_s.bod_sw_en[`BOD_HIGH] = wd[`BOD_EN]; // R10
						next_s.lvl_high = wd[`LVL_LO +: `LVL_W];
					end
					`OFS_REF_CAL: next_s.ref_cal = wd[`CAL_W-1:0];
					`OFS_REG_CAL: next_s.reg_cal = wd[`CAL_W-1:0];
					`OFS_REG_CTRL: next_s.pad_ctl = wd[`PAD_W-1:0]; // R14
					`OFS_SYS_RC: next_s.sys_cal = wd[`CAL_W-1:0];
					`OFS_MF_RC: begin
						next_s.mf_cal = wd[`CAL_W-1:0]; // R17
						next_s.freq_sel = wd[`FREQ_BIT]; // R16
					end
					`OFS_FAST_RC: next_s.fast_en = wd[`FAST_EN]; // R18
					default: ;
				endcase
			end
		end
		// A new event wins over a clear in the same cycle.
		next_s.flag_ae = (s.flag_ae & ~clr[`FLAG_AE]) | (wr && prot && !allowed); // R20
		next_s.flag_bod[`BOD_CORE] = (s.flag_bod[`BOD_CORE] & ~clr[`FLAG_CORE])
			| rise[`BOD_CORE]; // R21
		next_s.flag_bod[`BOD_MID] = (s.flag_bod[`BOD_MID] & ~clr[`FLAG_MID])
			| rise[`BOD_MID]; // R21
		next_s.flag_bod[`BOD_HIGH] = (s.flag_bod[`BOD_HIGH] & ~clr[`FLAG_HIGH])
			| rise[`BOD_HIGH]; // R21
		next_s.sts_prev = status;
		next_s.bod_en_q[`BOD_CORE] = s.bod_sw_en[`BOD_CORE] | s.fuse_core_en; // R4
		next_s.bod_en_q[`BOD_MID] = s.bod_sw_en[`BOD_MID] | s.fuse_mid_en; // R9
		next_s.bod_en_q[`BOD_HIGH] = s.bod_sw_en[`BOD_HIGH]; // R10
		next_s.core_irq = status[`BOD_CORE] && !s.bod_reset_sel[`BOD_CORE] && !dbg; // R5 R8
		next_s.core_rst = status[`BOD_CORE] && s.bod_reset_sel[`BOD_CORE] && !dbg; // R5 R8
		next_s.mid_irq = status[`BOD_MID] && !s.bod_reset_sel[`BOD_MID] && !dbg; // R9 R8
		next_s.mid_rst = status[`BOD_MID] && s.bod_reset_sel[`BOD_MID] && !dbg; // R9 R8
		next_s.high_irq = status[`BOD_HIGH] && !dbg; // R10 R8
		next_s.bandgap_on = !(deep_stop_sleep_in || static_sleep_in); // R12
		next_s.fast_rc_run = s.fast_en && !fast_rc_off_sleep_in; // R19
		next_s.pad_on = (s.pad_ctl != `PAD_OFF); // R14
		next_s.sys_rc_en = !static_sleep_in; // R15
		next_s.rc_prev = sys_rc_clk_in;
		if (static_sleep_in) begin
			next_s.rc_cnt = 2'h0; // R15
			next_s.sys_ready = 1'b0;
		end else if (sys_rc_clk_in && !s.rc_prev && !s.sys_ready) begin
			next_s.rc_cnt = s.rc_cnt + 2'h1;
			next_s.sys_ready = (s.rc_cnt == `SYS_RC_START - 2'h1); // R15
		end
		next_s.generic_clock_q = generic_clock_in; // R2 R3
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.lvl_core <= `LVL_RST;
			s.lvl_mid <= `LVL_RST;
			s.lvl_high <= `LVL_RST;
			s.ref_cal <= `CAL_RST;
			s.pad_ctl <= `PAD_RST;
			s.bandgap_on <= 1'b1;
			s.pad_on <= 1'b1;
			s.sys_rc_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_out = s.rdata;
	assign wb_ack_out = s.ack;
	assign bod_enable_out = s.bod_en_q;
	assign core_bod_level_out = s.lvl_core;
	assign mid_bod_level_out = s.lvl_mid;
	assign high_bod_level_out = s.lvl_high;
	assign core_bod_irq_out = s.core_irq;
	assign core_bod_reset_out = s.core_rst;
	assign mid_bod_irq_out = s.mid_irq;
	assign mid_bod_reset_out = s.mid_rst;
	assign high_bod_irq_out = s.high_irq;
	assign bandgap_on_out = s.bandgap_on;
	assign reference_calibration_out = s.ref_cal;
	assign core_regulator_calibration_out = s.reg_cal;
	assign pad_regulator_on_out = s.pad_on;
	assign sys_rc_enable_out = s.sys_rc_en;
	assign sys_rc_ready_out = s.sys_ready;
	assign system_rc_calibration_out = s.sys_cal;
	assign frequency_select_bit_out = s.freq_sel;
	assign multi_freq_calibration_out = s.mf_cal;
	assign fast_rc_enable_out = s.fast_rc_run;
	assign usb_clock_out = s.generic_clock_q[`GENERIC_CLOCK_USB];
	assign can_interface_clock_out = s.generic_clock_q[`GENERIC_CLOCK_CAN];
	assign asynchronous_timer_clock_out = s.generic_clock_q[`GENERIC_CLOCK_AST];
	assign pwm_clock_out = s.generic_clock_q[`GENERIC_CLOCK_PWM];
	assign quadrature_decoder_zero_clock_out = s.generic_clock_q[`GENERIC_CLOCK_QUADRATURE_DECODER_ZERO];
	assign quadrature_decoder_one_clock_out = s.generic_clock_q[`GENERIC_CLOCK_QUADRATURE_DECODER_ONE];
	assign generic_clock_event16_out = s.generic_clock_q[`GENERIC_CLOCK_EVT16];
	assign generic_clock_event17_out = s.generic_clock_q[`GENERIC_CLOCK_EVT17];
	assign generic_clock_pin_out = {s.generic_clock_q[`GENERIC_CLOCK_PIN1], s.generic_clock_q[`GENERIC_CLOCK_PIN0]};
	assign audio_serial_controller_clock_out = s.generic_clock_q[`GENERIC_CLOCK_AUDIO];

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence locked_core_write;
		wr && adr_w == `OFS_CORE_BOD && !allowed;
	endsequence
	sequence core_status_rise;
		$rose(status[`BOD_CORE]);
	endsequence
	a_locked_write_drop: assert property (locked_core_write |=> $stable(s.lvl_core)) // R11
		else $error("protected register changed without unlock");
	a_access_error_set: assert property (locked_core_write |=> s.flag_ae) // R20
		else $error("access error flag not set");
	a_core_flag_rise: assert property (core_status_rise |=> s.flag_bod[`BOD_CORE]) // R21
		else $error("core brownout flag missed a rising status");
	a_debug_mask_out: assert property (dbg |=> !core_bod_reset_out && !mid_bod_reset_out
		&& !core_bod_irq_out && !mid_bod_irq_out && !high_bod_irq_out) // R8
		else $error("detector request passed while debug enabled");
	a_bandgap_sleep_off: assert property ((deep_stop_sleep_in || static_sleep_in)
		|=> !bandgap_on_out) // R12
		else $error("bandgap on in deep stop or static sleep");
	a_fast_rc_sleep: assert property (fast_rc_off_sleep_in |=> !fast_rc_enable_out) // R19
		else $error("fast rc running in removing sleep mode");
	a_fuse_load_boot: assert property (s.boot == BOOT_LOAD |=>
		reference_calibration_out == $past(fuse_reference_cal_in)
		&& system_rc_calibration_out == $past(fuse_sys_rc_cal_in)) // R13
		else $error("calibration not loaded from fuses");
	a_sys_rc_static: assert property (static_sleep_in |=> !sys_rc_enable_out && !sys_rc_ready_out) // R15
		else $error("system rc available in static sleep");
	a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	a_ack_reply: assert property (take |=> wb_ack_out)
		else $error("request not acknowledged in one cycle");
	a_pad_off_code: assert property (s.pad_ctl == `PAD_OFF |=> !pad_regulator_on_out) // R14
		else $error("pad regulator on with off code");
	a_boot_no_ack: assert property (s.boot == BOOT_LOAD |=> !wb_ack_out)
		else $error("bus answered during fuse load cycle");
	a_fast_read_gate: assert property (take && !wb_we_in && !fast_rc_ready_in // R18
		&& adr_w == `OFS_FAST_RC |=> !wb_dat_out[`FAST_EN])
		else $error("fast rc enable read one before oscillator ran");
endmodule : supply_monitor_and_rc_source_control

//--- tb.sv
// Self-checking bench for the supply monitor and RC source control block.
`timescale 1ns/100ps
`include "supply_monitor_defs.svh"
module tb;
	import supply_monitor_pkg::*;
	logic clk_sys_in = 0, rst_n_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
	logic [`ADR_W-1:0] wb_adr_in = '0;
	logic [3:0] wb_sel_in = 4'hf;
	logic [31:0] wb_dat_in = '0, wb_dat_out, q;
	logic [2:0] bod_raw_in = '0, bod_enable_out;
	logic sys_rc_clk_in = 0, jtag_enable_in = 0, single_wire_debug_port_in = 0;
	logic deep_stop_sleep_in = 0, static_sleep_in = 0, fast_rc_off_sleep_in = 0;
	logic fast_rc_ready_in = 0, fuse_core_bod_en_in = 0, fuse_mid_bod_en_in = 1;
	logic [7:0] fuse_reference_cal_in = 8'h3c, fuse_core_reg_cal_in = 8'h5a;
	logic [7:0] fuse_sys_rc_cal_in = 8'h96, factory_multi_freq_trim_in = 8'hc3;
	logic [7:0] reference_calibration_out, core_regulator_calibration_out;
	logic [7:0] system_rc_calibration_out, multi_freq_calibration_out;
	logic [11:0] generic_clock_in = '0, generic_clock_seen;
	logic [5:0] core_bod_level_out, mid_bod_level_out, high_bod_level_out;
	logic wb_ack_out, core_bod_irq_out, core_bod_reset_out, mid_bod_irq_out, mid_bod_reset_out;
	logic high_bod_irq_out, bandgap_on_out, pad_regulator_on_out, sys_rc_enable_out;
	logic sys_rc_ready_out, frequency_select_bit_out, fast_rc_enable_out, usb_clock_out;
	logic can_interface_clock_out, asynchronous_timer_clock_out, pwm_clock_out;
	logic quadrature_decoder_zero_clock_out, quadrature_decoder_one_clock_out;
	logic generic_clock_event16_out, generic_clock_event17_out, audio_serial_controller_clock_out;
	logic [1:0] generic_clock_pin_out;
	logic [23:0] rows [3] = '{{12'h5a5, 12'h5a5}, {12'ha5a, 12'ha52}, {12'h008, 12'h000}};
	int error_cnt = 0, tests_run = 0;
	supply_monitor_and_rc_source_control DUT (.*);
	assign generic_clock_seen = {audio_serial_controller_clock_out, generic_clock_pin_out,
		generic_clock_event17_out, generic_clock_event16_out, quadrature_decoder_one_clock_out,
		quadrature_decoder_zero_clock_out, pwm_clock_out, 1'b0,
		asynchronous_timer_clock_out, can_interface_clock_out, usb_clock_out};
	task automatic chk(input string n, input logic [31:0] seen, want);
		tests_run++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, want, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : tick
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_in <= 1;
		wb_stb_in <= 1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		q = wb_dat_out;
		wb_cyc_in <= 0;
		wb_stb_in <= 0;
		if (wb_ack_out !== 1'b1) begin
			error_cnt++;
			summarize();
		end
		@(posedge clk_sys_in);
	endtask : wb
	task automatic pw(input logic [11:0] a, input logic [31:0] d);
		wb(1, `OFS_UNLOCK, {`UNLOCK_KEY, 14'h0, a[9:0]});
		wb(1, a, d);
	endtask : pw
	initial begin
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		tick(3);
		chk("bandgap", bandgap_on_out, 1);
		chk("pad", pad_regulator_on_out, 1);
		chk("rc_en", sys_rc_enable_out, 1);
		rst_n_in <= 1;
		tick(3);
		chk("refcal", reference_calibration_out, 8'h3c);
		chk("regcal", core_regulator_calibration_out, 8'h5a);
		chk("syscal", system_rc_calibration_out, 8'h96);
		chk("mfcal", multi_freq_calibration_out, 8'hc3);
		chk("bod_en", bod_enable_out, 3'h2);
		foreach (rows[i]) begin
			generic_clock_in <= '0;
			tick(1);
			generic_clock_in <= rows[i][23:12];
			tick(2);
			chk("generic_clock", generic_clock_seen, rows[i][11:0]);
		end
		wb(1, `OFS_CORE_BOD, 32'h0000_2a03);
		wb(0, `OFS_FLAGS, 0);
		chk("ae_flag", q, 32'h8000_0000);
		wb(1, `OFS_FLAG_CLR, 32'h8000_0000);
		wb(0, `OFS_CORE_BOD, 0);
		chk("locked", q, 0);
		for (int i = 0; i < 3; i++) begin
			chk("rc_ready", sys_rc_ready_out, 0);
			sys_rc_clk_in <= 1;
			tick(4);
			sys_rc_clk_in <= 0;
			tick(4);
		end
		chk("rc_ready", sys_rc_ready_out, 1);
		bod_raw_in <= 3'h1;
		pw(`OFS_CORE_BOD, 32'h0000_1503);
		chk("level", core_bod_level_out, 6'h15);
		chk("en", bod_enable_out, 3'h3);
		tick(6);
		chk("masked", core_bod_reset_out, 0);
		sys_rc_clk_in <= 1;
		tick(8);
		wb(0, `OFS_STATUS, 0);
		chk("status", q[`STS_CORE], 1);
		chk("rst_req", core_bod_reset_out, 1);
		chk("irq_req", core_bod_irq_out, 0);
		wb(0, `OFS_FLAGS, 0);
		chk("flags", q, 32'h0000_0040);
		jtag_enable_in <= 1;
		tick(3);
		chk("jtag", core_bod_reset_out, 0);
		jtag_enable_in <= 0;
		tick(3);
		chk("unmask", core_bod_reset_out, 1);
		single_wire_debug_port_in <= 1;
		tick(3);
		chk("swd", core_bod_reset_out, 0);
		single_wire_debug_port_in <= 0;
		bod_raw_in <= 3'h7;
		pw(`OFS_HIGH_BOD, 32'h0000_2a03);
		chk("high_lvl", high_bod_level_out, 6'h2a);
		sys_rc_clk_in <= 0;
		tick(8);
		chk("mid_irq", mid_bod_irq_out, 1);
		chk("mid_rst", mid_bod_reset_out, 0);
		chk("high_irq", high_bod_irq_out, 1);
		wb(0, `OFS_HIGH_BOD, 0);
		chk("high_ctl", q, 32'h0000_2a01);
		single_wire_debug_port_in <= 1;
		tick(3);
		chk("swd_all", core_bod_reset_out | mid_bod_irq_out | high_bod_irq_out, 0);
		pw(`OFS_REG_CTRL, 32'h0000_0003);
		chk("pad_off", pad_regulator_on_out, 0);
		pw(`OFS_MF_RC, 32'h0001_005c);
		chk("freq", frequency_select_bit_out, 1);
		chk("mfcal", multi_freq_calibration_out, 8'h5c);
		wb(1, `OFS_FAST_RC, 1);
		wb(0, `OFS_FAST_RC, 0);
		chk("fast", q[0], 0);
		fast_rc_ready_in <= 1;
		tick(2);
		wb(0, `OFS_FAST_RC, 0);
		chk("fast", q[0], 1);
		chk("fast_en", fast_rc_enable_out, 1);
		fast_rc_off_sleep_in <= 1;
		tick(2);
		chk("fast_sleep", fast_rc_enable_out, 0);
		deep_stop_sleep_in <= 1;
		tick(2);
		chk("bg_deep", bandgap_on_out, 0);
		deep_stop_sleep_in <= 0;
		static_sleep_in <= 1;
		tick(2);
		chk("bg_static", bandgap_on_out, 0);
		chk("rc_static", sys_rc_enable_out, 0);
		wb(0, 12'h3fc, 0);
		chk("unmapped", q, 0);
		rst_n_in <= 0;
		fuse_core_bod_en_in <= 1;
		fuse_reference_cal_in <= 8'h69;
		tick(3);
		chk("rst_mf", multi_freq_calibration_out, 8'h00);
		rst_n_in <= 1;
		tick(3);
		chk("refcal2", reference_calibration_out, 8'h69);
		chk("bod_en2", bod_enable_out, 3'h3);
		summarize();
	end
endmodule : tb
